// ==== touch_mode_sequencer.v ====
// Functional notes
// - Tick period register sets primary tick only in full run; else fixed 8 ms.
// - Primary tick period in milliseconds is tick code plus five.
// - Writes giving a period outside 5..31 ms force the code to 0x1A.
// - Duty run keeps scanning but idles in low power between scans.
// - Run and duty-disable bits together select one of four modes.
// - Duty run and off stop are left only by a wake pin edge.
// - Config stop halts scanning, answers access, and alone allows other writes.
// - Off stop neither scans nor acknowledges serial transactions.
// - Minimum interrupt gap is primary tick times spacing field plus one.
// - Config bit 4 written low asserts global controller reset.
// - Config bit 2 is active-low duty cycle control.
// - Interrupt output is driven only while config bit 1 is set.
// - Config bit 0 high selects run modes and enables scanning.
// - Wake pin falling edge sets the duty-cycle-disable bit.
// - Idle timeout and sleep factors apply only in duty run.
// - Fast scan period is ((code+5)/8+1) x sample x 4 x 8 ms.
// - Slow scan period multiplies that product by the sleep cycle factor.
// - Idle timeout is ((code+5)/8+1) x sample x idle factor x 6 x 8 ms.
// - Duty run starts fast, slows after idle, returns fast on touch.
// - In full run only the mode config register accepts writes; duty run accepts none.
// - Full run runs continuously, all ticks follow the programmed period.
// - After reset mode config holds 0x14: config stop, interrupts off.
// - Zero idle or sleep factor disables slow scanning entirely.
`timescale 1ns/100ps
`default_nettype none
`include "touch_mode_defines.vh"
module touch_mode_sequencer #(
    parameter CYCLES_PER_MS = `TMS_MS_TIME_NS / `TMS_CLK_PERIOD_NS,
    parameter SPAN_WIDTH = 20
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Register port from the serial front end
    input wire regWrite,
    input wire [7:0] regAddr,
    input wire [7:0] regWriteData,
    output reg [7:0] regReadData,
    output reg regHit,
    output reg serialAck,
    output reg otherWriteEnable,
    // Wake pin, asynchronous
    input wire wakePin,
    // Sensing side
    input wire touchDetected,
    input wire interruptRequest,
    input wire [7:0] samplePeriodTicks,
    input wire [2:0] idleTimeoutFactor,
    input wire [4:0] sleepCycleFactor,
    // Mode and timing outputs
    output reg [1:0] modeState,
    output reg scanEnable,
    output reg primaryTick,
    output reg scanTick,
    output reg slowScan,
    output reg lowPowerIdle,
    output reg controllerResetN,
    output reg irqN
);

// Mode codes, {run bit, duty-cycle-disable bit}
localparam [1:0] OFF_STOP = 2'b00;
localparam [1:0] CONFIG_STOP = 2'b01;
localparam [1:0] DUTY_RUN = 2'b10;
localparam [1:0] FULL_RUN = 2'b11;

localparam [31:0] MS_WIDE = CYCLES_PER_MS;
localparam [SPAN_WIDTH-1:0] MS_LIMIT = MS_WIDE[SPAN_WIDTH-1:0];

reg [7:0] tickPeriodCode;
reg [7:0] modeConfig;
reg [7:0] next_modeConfig;
reg [1:0] lastMode;
reg irqPending;
reg irqActive;
reg [3:0] gapLeft;

wire wakeFall;
wire msTick;
wire primaryDone;
wire scanDone;
wire idleDone;

// Current mode straight from the two mode bits
wire [1:0] mode = {modeConfig[`TMS_RUN_BIT],
                   modeConfig[`TMS_DUTY_DIS_BIT]};
wire inFullRun = (mode == FULL_RUN);
wire inDutyRun = (mode == DUTY_RUN);
wire inConfigStop = (mode == CONFIG_STOP);

// Only these two modes take serial writes; the others wait for wake
wire writeOpen = inFullRun | inConfigStop;
wire cfgWrite = regWrite & writeOpen &
                (regAddr == `TMS_MODE_CONFIG_ADDR);
wire tickWrite = regWrite & inConfigStop &
                 (regAddr == `TMS_TICK_PERIOD_ADDR);

// Out-of-range codes are replaced rather than clipped
wire tickCodeBad = (regWriteData > `TMS_TICK_CODE_MAX);
wire [7:0] tickCodeIn = tickCodeBad ? `TMS_TICK_CODE_FORCED
                                    : regWriteData;

// Primary tick length in milliseconds
wire [7:0] progTickMs = tickPeriodCode + `TMS_TICK_OFFSET_MS;
wire [7:0] tickMs = inFullRun ? progTickMs
                              : `TMS_FIXED_TICK_MS;
wire [SPAN_WIDTH-1:0] tickLimit = {{(SPAN_WIDTH-8){1'b0}}, tickMs};

// Duty run spans, counted in fixed 8 ms primary ticks
wire [7:0] dutyBase8 = (progTickMs >> `TMS_DUTY_CLK_SHIFT) + 8'h01;
wire [SPAN_WIDTH-1:0] dutyBase = {{(SPAN_WIDTH-8){1'b0}}, dutyBase8};
wire [SPAN_WIDTH-1:0] sampleSpan =
    {{(SPAN_WIDTH-8){1'b0}}, samplePeriodTicks};
wire [SPAN_WIDTH-1:0] sleepSpan =
    {{(SPAN_WIDTH-5){1'b0}}, sleepCycleFactor};
wire [SPAN_WIDTH-1:0] idleSpanF =
    {{(SPAN_WIDTH-3){1'b0}}, idleTimeoutFactor};
wire [SPAN_WIDTH-1:0] fastSpan =
    dutyBase * sampleSpan * `TMS_DEBOUNCE_SAMPLES;
wire [SPAN_WIDTH-1:0] slowSpan = fastSpan * sleepSpan;
wire [SPAN_WIDTH-1:0] idleSpan =
    dutyBase * sampleSpan * idleSpanF * `TMS_IDLE_SCALE;

// Either zero factor keeps duty run at the fast rate for good
wire lowPowerAllowed = (idleTimeoutFactor != 3'h0) &&
                       (sleepCycleFactor != 5'h00);

wire modeChanged = (mode != lastMode);
wire enteringDuty = inDutyRun & modeChanged;

// Soft reset bit is active low
wire softReset = ~modeConfig[`TMS_RESET_BIT];
wire irqEnabled = modeConfig[`TMS_IRQ_EN_BIT];
wire [3:0] gapReload = {1'b0, modeConfig[`TMS_SPACING_HI:
                                         `TMS_SPACING_LO]} + 4'h1;
wire irqIssue = irqPending & irqEnabled & ~irqActive &
                (gapLeft == 4'h0) & ~softReset;

// Wake pin passes the synchroniser before anything looks at it
pin_sync wakeSync (
    .clk(clk),
    .rst(rst),
    .pin(wakePin),
    .level(),
    .fall(wakeFall)
);

// One millisecond base from the system clock
tick_divider #(
    .WIDTH(SPAN_WIDTH)
) msDivider (
    .clk(clk),
    .rst(rst),
    .restart(1'b0),
    .step(1'b1),
    .limit(MS_LIMIT),
    .done(msTick)
);

// Primary tick, restarted on a mode change so the new length is clean
tick_divider #(
    .WIDTH(SPAN_WIDTH)
) primaryDivider (
    .clk(clk),
    .rst(rst),
    .restart(modeChanged),
    .step(msTick),
    .limit(tickLimit),
    .done(primaryDone)
);

// Duty run scan period, fast or slow
tick_divider #(
    .WIDTH(SPAN_WIDTH)
) scanDivider (
    .clk(clk),
    .rst(rst),
    .restart(~inDutyRun | enteringDuty),
    .step(primaryDone),
    .limit(slowScan ? slowSpan : fastSpan),
    .done(scanDone)
);

// Idle timer runs only while scanning fast without touches
tick_divider #(
    .WIDTH(SPAN_WIDTH)
) idleDivider (
    .clk(clk),
    .rst(rst),
    .restart(~inDutyRun | enteringDuty | slowScan |
             touchDetected),
    .step(primaryDone),
    .limit(idleSpan),
    .done(idleDone)
);

// Config write merged with the wake edge; the edge always wins bit 2
always @* begin
    next_modeConfig = modeConfig;
    if (cfgWrite) begin
        next_modeConfig = regWriteData;
    end
    next_modeConfig[`TMS_UNUSED_BIT] = 1'b0;
    if (wakeFall) begin
        next_modeConfig[`TMS_DUTY_DIS_BIT] = 1'b1;
    end
end

// Register file
always @(posedge clk) begin
    if (rst) begin
        modeConfig <= `TMS_MODE_CONFIG_RESET;
        tickPeriodCode <= `TMS_TICK_PERIOD_RESET;
        lastMode <= CONFIG_STOP;
    end else begin
        modeConfig <= next_modeConfig;
        lastMode <= mode;
        if (tickWrite) begin
            tickPeriodCode <= tickCodeIn;
        end
    end
end

// Read path and serial acknowledge, registered
always @(posedge clk) begin
    if (rst) begin
        regReadData <= 8'h00;
        regHit <= 1'b0;
        serialAck <= 1'b0;
        otherWriteEnable <= 1'b0;
    end else begin
        if (regAddr == `TMS_TICK_PERIOD_ADDR) begin
            regReadData <= tickPeriodCode;
            regHit <= 1'b1;
        end else if (regAddr == `TMS_MODE_CONFIG_ADDR) begin
            regReadData <= modeConfig;
            regHit <= 1'b1;
        end else begin
            regReadData <= 8'h00;
            regHit <= 1'b0;
        end
        // Duty run may drop access, so it is refused outright
        serialAck <= writeOpen;
        otherWriteEnable <= inConfigStop;
    end
end

// Scan control and tick outputs
always @(posedge clk) begin
    if (rst) begin
        modeState <= CONFIG_STOP;
        scanEnable <= 1'b0;
        primaryTick <= 1'b0;
        scanTick <= 1'b0;
        lowPowerIdle <= 1'b0;
        controllerResetN <= 1'b1;
    end else begin
        modeState <= mode;
        scanEnable <= modeConfig[`TMS_RUN_BIT] & ~softReset;
        primaryTick <= primaryDone;
        controllerResetN <= ~softReset;
        if (softReset) begin
            scanTick <= 1'b0;
        end else if (inFullRun) begin
            scanTick <= primaryDone;
        end else if (inDutyRun) begin
            scanTick <= scanDone;
        end else begin
            scanTick <= 1'b0;
        end
        // Low power between scans, awake only in the scan cycle
        lowPowerIdle <= inDutyRun & ~scanDone;
    end
end

// Fast and slow scan rate in duty run
always @(posedge clk) begin
    if (rst) begin
        slowScan <= 1'b0;
    end else if (~inDutyRun | enteringDuty | ~lowPowerAllowed) begin
        slowScan <= 1'b0;
    end else if (touchDetected) begin
        slowScan <= 1'b0;
    end else if (idleDone) begin
        slowScan <= 1'b1;
    end
end

// Interrupt pending, spacing and output
always @(posedge clk) begin
    if (rst) begin
        irqPending <= 1'b0;
        irqActive <= 1'b0;
        gapLeft <= 4'h0;
        irqN <= 1'b1;
    end else if (~irqEnabled | softReset) begin
        // Suppressed: nothing is held for later
        irqPending <= 1'b0;
        irqActive <= 1'b0;
        gapLeft <= 4'h0;
        irqN <= 1'b1;
    end else begin
        // A new request in the issue cycle stays pending
        irqPending <= (irqPending & ~irqIssue) | interruptRequest;
        if (irqIssue) begin
            gapLeft <= gapReload;
            irqActive <= 1'b1;
            irqN <= 1'b0;
        end else begin
            if (primaryDone && gapLeft != 4'h0) begin
                gapLeft <= gapLeft - 4'h1;
            end
            if (primaryDone) begin
                irqActive <= 1'b0;
                irqN <= 1'b1;
            end
        end
    end
end

endmodule // touch_mode_sequencer
`default_nettype wire

// ==== touch_mode_defines.vh ====
`ifndef TOUCH_MODE_DEFINES_VH
`define TOUCH_MODE_DEFINES_VH
// Register offsets
`define TMS_TICK_PERIOD_ADDR 8'h0E
`define TMS_MODE_CONFIG_ADDR 8'h13
// Reset values
`define TMS_TICK_PERIOD_RESET 8'h05
`define TMS_MODE_CONFIG_RESET 8'h14
// Tick period code limits
`define TMS_TICK_CODE_MAX 8'h1A
`define TMS_TICK_CODE_FORCED 8'h1A
`define TMS_TICK_OFFSET_MS 8'h05
`define TMS_FIXED_TICK_MS 8'h08
// Mode config field positions
`define TMS_SPACING_HI 7
`define TMS_SPACING_LO 5
`define TMS_RESET_BIT 4
`define TMS_UNUSED_BIT 3
`define TMS_DUTY_DIS_BIT 2
`define TMS_IRQ_EN_BIT 1
`define TMS_RUN_BIT 0
// Timing
`define TMS_CLK_PERIOD_NS 4
`define TMS_MS_TIME_NS 1000000
`define TMS_DUTY_CLK_SHIFT 3
`define TMS_DEBOUNCE_SAMPLES 20'h00004
`define TMS_IDLE_SCALE 20'h00006
`endif

// ==== pin_sync.v ====
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Pin and its events
    input wire pin,
    output reg level,
    output reg fall
);

reg stage1;
reg stage2;

// Two flops before any logic; the first feeds only the second
always @(posedge clk) begin
    if (rst) begin
        stage1 <= 1'b1;
        stage2 <= 1'b1;
        level <= 1'b1;
        fall <= 1'b0;
    end else begin
        stage1 <= pin;
        stage2 <= stage1;
        level <= stage2;
        fall <= level & ~stage2;
    end
end

endmodule // pin_sync
`default_nettype wire

// ==== tick_divider.v ====
`timescale 1ns/100ps
`default_nettype none
module tick_divider #(
    parameter WIDTH = 20
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Counting control
    input wire restart,
    input wire step,
    input wire [WIDTH-1:0] limit,
    output reg done
);

reg [WIDTH-1:0] count;
wire [WIDTH-1:0] nextCount = count + {{(WIDTH-1){1'b0}}, 1'b1};

// A limit of zero behaves as one, so a step never stalls
always @(posedge clk) begin
    if (rst || restart) begin
        count <= {WIDTH{1'b0}};
        done <= 1'b0;
    end else if (step && nextCount >= limit) begin
        count <= {WIDTH{1'b0}};
        done <= 1'b1;
    end else begin
        count <= step ? nextCount : count;
        done <= 1'b0;
    end
end

endmodule // tick_divider
`default_nettype wire

// ==== host_wake_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module host_wake_model (
    // Request from the host sequence
    input wire logic pulse,
    // Wake pin toward the device, idles high
    output var logic wakePin
);
    initial wakePin = 1'b1;
    // Host pulses wake on each request from the sequence, half of 80 ns
    always @(posedge pulse) begin
        wakePin = 1'b0;
        #40 wakePin = 1'b1;
    end
endmodule // host_wake_model
`default_nettype wire

// ==== touch_mode_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module touch_mode_checker #(
    parameter CYCLES_PER_MS = 10
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Watched ports
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regReadData,
    input wire logic regHit,
    input wire logic serialAck,
    input wire logic otherWriteEnable,
    input wire logic wakePin,
    input wire logic [1:0] modeState,
    input wire logic scanEnable,
    input wire logic primaryTick,
    input wire logic irqN
);
    localparam int FIXED = 8 * CYCLES_PER_MS - 1;
    logic [3:0] wakeAge;
    logic [23:0] tickGap;
    logic clean;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Age of the last wake fall; an exit from duty run or off stop must follow one closely
    always @(posedge clk) begin
        if (rst || $fell(wakePin)) wakeAge <= 4'h0;
        else if (wakeAge != 4'hF) wakeAge <= wakeAge + 4'h1;
    end
    // Tick spacing; a mode change restarts the tick, so skip that gap
    always @(posedge clk) begin
        tickGap <= (rst || primaryTick) ? 24'h0 : tickGap + 24'h1;
        if (rst || modeState != $past(modeState)) clean <= 1'b0;
        else if (primaryTick) clean <= 1'b1;
    end
    property p_bit3; regHit && $past(regAddr) == 8'h13 |-> !regReadData[3];
    endproperty
    property p_no_ack; !modeState[0] |-> !serialAck; endproperty
    property p_other;
        otherWriteEnable |-> modeState == 2'b01 || $past(modeState) == 2'b01;
    endproperty
    property p_scan; scanEnable |-> modeState[1] || $past(modeState[1]);
    endproperty
    property p_irq_len; $rose(irqN) |-> primaryTick || $past(primaryTick);
    endproperty
    property p_wake; $fell(wakePin) && !modeState[0] |-> ##[1:12] modeState[0];
    endproperty
    property p_stay;
        !$past(modeState[0]) && modeState != $past(modeState) |-> wakeAge < 4'hC;
    endproperty
    // A tick launched in the old mode lands in the same cycle as the modeState change
    property p_fixed;
        primaryTick && clean && modeState != 2'b11 &&
            modeState == $past(modeState) |-> tickGap == FIXED;
    endproperty
    a_bit3: assert property (p_bit3)
        else $error("reserved bit reads one");
    a_no_ack: assert property (p_no_ack)
        else $error("ack while duty cycling");
    a_other: assert property (p_other)
        else $error("other writes outside config stop");
    a_scan: assert property (p_scan)
        else $error("scan enabled in stop mode");
    a_irq_len: assert property (p_irq_len)
        else $error("irq released off tick");
    a_wake: assert property (p_wake)
        else $error("wake fall ignored");
    a_stay: assert property (p_stay)
        else $error("mode left without wake");
    a_fixed: assert property (p_fixed)
        else $error("fixed tick span wrong");
    // Main scenarios reached
    c_full: cover property (modeState == 2'b11);
    c_irq: cover property ($fell(irqN));
    c_wake: cover property ($fell(wakePin) && !modeState[0]);
endmodule // touch_mode_checker
bind touch_mode_sequencer touch_mode_checker #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
) i_touch_mode_checker (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regReadData(regReadData),
    .regHit(regHit), .serialAck(serialAck),
    .otherWriteEnable(otherWriteEnable), .wakePin(wakePin),
    .modeState(modeState), .scanEnable(scanEnable),
    .primaryTick(primaryTick), .irqN(irqN)
);
`default_nettype wire

// ==== touch_mode_sequencer_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
    err_total++; $display("[ERR] %s exp %h got %h", n, e, a); end end
`define WAITC(c) begin cnt = 0; while (!(c) && cnt < 3000) begin \
    @(negedge clk); cnt++; end if (!(c)) begin err_total++; \
    $display("[ERR] wait exp 1 got 0"); end_of_test; end end
module touch_mode_sequencer_tb;
    localparam int MS = 10;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic regWrite = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWriteData = 8'h00;
    logic touchDetected = 1'b0;
    logic interruptRequest = 1'b0;
    logic [7:0] samplePeriodTicks = 8'h01;
    logic [2:0] idleTimeoutFactor = 3'h1;
    logic [4:0] sleepCycleFactor = 5'h01;
    logic wakeReq = 1'b0;
    logic [7:0] d;
    logic [7:0] codes [4] = '{8'h1B, 8'hFF, 8'h1A, 8'h00};
    logic [7:0] kept [4] = '{8'h1A, 8'h1A, 8'h1A, 8'h00};
    int cnt, n, err_total = 0, comparisons = 0;
    wire [7:0] regReadData;
    wire [1:0] modeState;
    wire regHit, serialAck, otherWriteEnable, wakePin, scanEnable;
    wire primaryTick, scanTick, slowScan, lowPowerIdle, controllerResetN, irqN;
    touch_mode_sequencer #(.CYCLES_PER_MS(MS), .SPAN_WIDTH(20))
    i_touch_mode_sequencer (
        .clk(clk), .rst(rst), .regWrite(regWrite), .regAddr(regAddr),
        .regWriteData(regWriteData), .regReadData(regReadData),
        .regHit(regHit), .serialAck(serialAck),
        .otherWriteEnable(otherWriteEnable), .wakePin(wakePin),
        .touchDetected(touchDetected), .interruptRequest(interruptRequest),
        .samplePeriodTicks(samplePeriodTicks),
        .idleTimeoutFactor(idleTimeoutFactor),
        .sleepCycleFactor(sleepCycleFactor), .modeState(modeState),
        .scanEnable(scanEnable), .primaryTick(primaryTick),
        .scanTick(scanTick), .slowScan(slowScan),
        .lowPowerIdle(lowPowerIdle), .controllerResetN(controllerResetN),
        .irqN(irqN)
    );
    host_wake_model i_host_wake_model (.pulse(wakeReq), .wakePin(wakePin));
    // 250 MHz system clock
    always #2 clk = ~clk;
    // Byte write: strobe for exactly one taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        regAddr = a;
        regWriteData = v;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
    endtask
    // Read answers one edge after the address settles; the task samples after two
    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        regAddr = a;
        repeat (2) @(negedge clk);
        d = regReadData;
    endtask
    // Span between two primary ticks, in clocks
    task automatic tickSpan;
        `WAITC(primaryTick)
        @(negedge clk);
        `WAITC(primaryTick)
        n = cnt + 1;
    endtask
    // Wake pulse, then wait for the expected mode
    task automatic wake(input logic [1:0] m);
        @(negedge clk);
        wakeReq = 1'b1;
        @(negedge clk);
        wakeReq = 1'b0;
        `WAITC(modeState === m)
    endtask
    task automatic end_of_test;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        rd(8'h13); `CHK("config", 8'h14, d)
        `CHK("mode", 2'b01, modeState)
        rd(8'h55); `CHK("unmapped", 8'h00, d)
        `CHK("hit", 1'b0, regHit)
        `CHK("other wr", 1'b1, otherWriteEnable)
        foreach (codes[i]) begin
            wr(8'h0E, codes[i]);
            rd(8'h0E); `CHK("tick", kept[i], d)
        end
        tickSpan; `CHK("stop span", 8 * MS, n)
        `CHK("stop scan", 1'b0, scanTick)
        wr(8'h13, 8'h1F);
        rd(8'h13); `CHK("config", 8'h17, d)
        `CHK("mode", 2'b11, modeState)
        `CHK("run wr", 1'b0, otherWriteEnable)
        wr(8'h0E, 8'h03);
        rd(8'h0E); `CHK("tick", 8'h00, d)
        tickSpan; `CHK("run span", 5 * MS, n)
        `CHK("run scan", 1'b1, scanTick)
        @(negedge clk) interruptRequest = 1'b1;
        @(negedge clk) interruptRequest = 1'b0;
        @(negedge clk);
        `CHK("irq", 1'b0, irqN)
        `WAITC(irqN === 1'b1)
        wr(8'h13, 8'h1D);
        @(negedge clk) interruptRequest = 1'b1;
        @(negedge clk) interruptRequest = 1'b0;
        repeat (20) @(negedge clk);
        `CHK("irq off", 1'b1, irqN)
        wr(8'h13, 8'h11);
        repeat (3) @(negedge clk);
        `CHK("mode", 2'b10, modeState)
        `CHK("ack", 1'b0, serialAck)
        `CHK("low power", 1'b1, lowPowerIdle)
        wr(8'h13, 8'h15);
        repeat (3) @(negedge clk);
        `CHK("mode", 2'b10, modeState)
        `WAITC(slowScan === 1'b1)
        `CHK("idle span", 1'b1, cnt > 400 && cnt < 500)
        touchDetected = 1'b1;
        @(negedge clk);
        `CHK("fast", 1'b0, slowScan)
        touchDetected = 1'b0;
        wake(2'b11);
        `CHK("wake lag", 1'b1, cnt < 6)
        idleTimeoutFactor = 3'h0;
        wr(8'h13, 8'h11);
        repeat (1000) @(negedge clk);
        `CHK("no slow", 1'b0, slowScan)
        wake(2'b11);
        wr(8'h13, 8'h10);
        repeat (3) @(negedge clk);
        `CHK("off ack", 1'b0, serialAck)
        `CHK("off scan", 1'b0, scanEnable)
        wake(2'b01);
        `CHK("wake lag", 1'b1, cnt < 6)
        `CHK("stop ack", 1'b1, serialAck)
        wr(8'h13, 8'h04);
        repeat (3) @(negedge clk);
        `CHK("soft reset", 1'b0, controllerResetN)
        end_of_test;
    end
endmodule // touch_mode_sequencer_tb
`default_nettype wire
